// file: design/sal_age_timer.sv
// aging sweep timer: one pulse per quarter of the aging period
// assumes period_s is in seconds and clk runs at the core rate
`timescale 1ns/1ps
`include "sal_consts.svh"

module sal_age_timer #(
  parameter int QTR_CYC = `SAL_QTR_CYC
) (
  input  logic        clk,
  input  logic        rst,
  input  logic        en,
  input  logic [10:0] period_s,
  output logic        tick
);

  localparam int CW = $clog2(QTR_CYC + 1);

  logic [CW-1:0] cyc_q, cyc_d;
  logic [10:0]   qtr_q, qtr_d;
  logic [10:0]   lim;
  logic          tick_q, tick_d;

  // ----------------------------------------------------------------
  // quarter second divider and period counter
  // ----------------------------------------------------------------
  always_comb begin
    // zero selects the default period
    if (period_s == 11'd0) begin
      lim = `SAL_AGE_PERIOD_S;
    end else if (period_s < `SAL_AGE_MIN_S) begin
      lim = `SAL_AGE_MIN_S;
    end else if (period_s > `SAL_AGE_MAX_S) begin
      lim = `SAL_AGE_MAX_S;
    end else begin
      lim = period_s;
    end
    cyc_d  = cyc_q;
    qtr_d  = qtr_q;
    tick_d = 1'b0;
    if (!en) begin
      cyc_d = '0;
      qtr_d = '0;
    end else if (cyc_q == CW'(QTR_CYC - 1)) begin
      cyc_d = '0;
      if (qtr_q >= lim - 11'd1) begin
        qtr_d  = '0;
        tick_d = 1'b1;
      end else begin
        qtr_d = qtr_q + 11'd1;
      end
    end else begin
      cyc_d = cyc_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_q  <= '0;
      qtr_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cyc_q  <= cyc_d;
      qtr_q  <= qtr_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// file: design/sal_lookup_engine.sv
// address lookup, learning, aging and forwarding decision engine
// assumes headers come from ingress ports already parsed, and that
// spanning tree, snooping, vlan and acl results arrive with them
`timescale 1ns/1ps
`include "sal_consts.svh"

// Notes on behaviour
// (R1) sixteen static entries, software written, searched with the dynamic table
// (R2) eight reserved multicast groups, off after reset, bitmaps rewritable
// (R3) bitmaps are 7 bits, bit 6 port 7; group 3 floods
// (R4) group 0 defaults to highest port only
// (R5) group 1, mac control, defaults to drop
// (R6) groups 2 and 6 default to highest port only
// (R7) groups 4, 5 and 7 flood all but the highest port
// (R8) a destination hit takes its port set from the entry
// (R9) static results win over dynamic results
// (R10) learn only absent, error free, legal length, unicast sources
// (R11) new entry holds address, port, age; full bucket evicts oldest dynamic
// (R12) all-static bucket: no learning, pulse and capture bucket index
// (R13) known source on another port moves to the new port
// (R14) seen sources refresh age; unrefreshed dynamic entries are removed
// (R15) aging runs when enabled; period default 300 s, 1 s to 30 min
// (R16) aging never removes static entries
// (R17) stage one list is trimmed by tree, snooping, vlan masks; mirror ports are added
// (R18) acl result overrides to give the final list
// (R19) framing, fcs, alignment and size errors are never forwarded
// (R20) pause frames are consumed and signalled to the port for flow control
// (R21) destination equal to ingress port is local and dropped
// (R22) in-band management frames go nowhere
// (R23) dynamic table is 1k four-way buckets, all ways compared at once
module sal_lookup_engine
  import sal_pkg::*;
#(
  parameter int IDX_W   = `SAL_IDX_W,
  parameter int QTR_CYC = `SAL_QTR_CYC
) (
  input  logic             clk,
  input  logic             rst,
  input  logic             hdr_valid,
  output logic             hdr_ready,
  input  sal_hdr_t         hdr,
  input  sal_pmap_t        vlan_members,
  input  sal_pmap_t        fwd_allow_mask,
  input  sal_pmap_t        mirror_ports,
  input  logic             acl_override,
  input  sal_pmap_t        acl_ports,
  output logic             dec_valid,
  output sal_pmap_t        stage_one_port_list,
  output sal_pmap_t        final_port_list,
  output sal_drop_t        dec_drop,
  output logic             pause_seen,
  output logic [2:0]       pause_port,
  output logic             learn_full,
  output logic [IDX_W-1:0] learn_full_index,
  output logic             mgmt_ready,
  input  logic             stat_wr,
  input  logic [3:0]       stat_wr_idx,
  input  sal_stat_t        stat_wr_data,
  input  logic             rsv_enable,
  input  logic             rsv_wr,
  input  logic [2:0]       rsv_wr_grp,
  input  sal_pmap_t        rsv_wr_map,
  input  logic             dyn_wr,
  input  logic [IDX_W-1:0] dyn_wr_idx,
  input  logic [1:0]       dyn_wr_way,
  input  sal_dyn_t         dyn_wr_data,
  input  logic             age_enable,
  input  logic [10:0]      age_period_s
);

  localparam int NBKT = 1 << IDX_W;
  localparam int WAYS = `SAL_WAYS;
  localparam sal_pmap_t RSV_DEF [`SAL_RSV_N] = '{
    `SAL_RSV0_MAP, `SAL_RSV1_MAP, `SAL_RSV2_MAP, `SAL_RSV3_MAP,
    `SAL_RSV4_MAP, `SAL_RSV5_MAP, `SAL_RSV6_MAP, `SAL_RSV7_MAP};

  sal_state_t       state_q, state_d;
  sal_hdr_t         hdr_q, hdr_d;
  logic             sweep_pend_q, sweep_pend_d;
  logic [IDX_W-1:0] sweep_idx_q, sweep_idx_d;
  logic             dec_valid_q, dec_valid_d;
  sal_pmap_t        s1_q, s1_d;
  sal_pmap_t        fin_q, fin_d;
  sal_drop_t        drop_q, drop_d;
  logic             pause_q, pause_d;
  logic             full_q, full_d;
  logic [IDX_W-1:0] full_idx_q, full_idx_d;
  sal_bucket_t      tbl_q [NBKT];
  sal_stat_t        stat_q [`SAL_STAT_N];
  sal_pmap_t        rsv_q [`SAL_RSV_N];

  logic             sweep_tick;
  logic [IDX_W-1:0] da_idx, sa_idx, rd_idx;
  sal_bucket_t      bkt, nb;
  logic             wr_en;
  logic [3:0]       rsv_info;
  logic             rsv_hit, stat_hit, dyn_hit, any_hit, hdr_err;
  sal_pmap_t        stat_map, dyn_bit, src_bit, s1, adj;
  logic [2:0]       dyn_port;
  logic [WAYS-1:0]  keep_static;

  // ----------------------------------------------------------------
  // aging timer
  // ----------------------------------------------------------------
  sal_age_timer #(
    .QTR_CYC (QTR_CYC)
  ) u_age_timer (
    .clk      (clk),
    .rst      (rst),
    .en       (age_enable),        // see (R15)
    .period_s (age_period_s),
    .tick     (sweep_tick)
  );

  // ----------------------------------------------------------------
  // bucket index and read
  // ----------------------------------------------------------------
  function automatic logic [3:0] rsv_group(input logic [7:0] b);
    if (b == 8'h00) return 4'h8;
    if (b == 8'h01) return 4'h9;
    if (b == 8'h03) return 4'ha;
    if (b == 8'h10) return 4'hb;
    if (b == 8'h20) return 4'hc;
    if (b == 8'h21) return 4'hd;
    if (b == 8'h02 || (b >= 8'h04 && b <= 8'h0f)) return 4'he;
    if ((b >= 8'h11 && b <= 8'h1f) || (b >= 8'h22 && b <= 8'h2f))
      return 4'hf;
    return 4'h0;
  endfunction

  // direct hash of low address bits plus filter group id
  assign da_idx = hdr_q.da[IDX_W-1:0] + IDX_W'(hdr_q.filter_group_id);
  assign sa_idx = hdr_q.sa[IDX_W-1:0] + IDX_W'(hdr_q.filter_group_id);

  always_comb begin
    unique case (state_q)
      ST_DA:    rd_idx = da_idx;
      ST_SA:    rd_idx = sa_idx;
      ST_SWEEP: rd_idx = sweep_idx_q;
      ST_IDLE:  rd_idx = dyn_wr_idx;
    endcase
  end

  assign bkt     = tbl_q[rd_idx];
  assign hdr_err = hdr_q.err_frame | hdr_q.err_fcs | hdr_q.err_align |
                   hdr_q.err_size;

  // ----------------------------------------------------------------
  // destination lookup
  // ----------------------------------------------------------------
  always_comb begin
    rsv_info = rsv_group(hdr_q.da[7:0]);
    rsv_hit  = rsv_enable && rsv_info[3] &&
               hdr_q.da[47:8] == `SAL_RSV_PREFIX;  // see (R2)
    stat_hit = 1'b0;
    stat_map = '0;
    // lowest index wins among static entries
    for (int i = `SAL_STAT_N - 1; i >= 0; i--) begin
      if (stat_q[i].valid && stat_q[i].mac == hdr_q.da &&
          stat_q[i].filter_group_id == hdr_q.filter_group_id) begin  // see (R1)
        stat_hit = 1'b1;
        stat_map = stat_q[i].ports;
      end
    end
    dyn_hit  = 1'b0;
    dyn_port = '0;
    for (int w = 0; w < WAYS; w++) begin
      // all ways compared together; static ways take precedence
      if (bkt[w].valid && bkt[w].mac == hdr_q.da &&
          bkt[w].filter_group_id == hdr_q.filter_group_id) begin  // see (R23)
        if (!dyn_hit || bkt[w].is_static) begin  // see (R9)
          dyn_port = bkt[w].port;
        end
        dyn_hit = 1'b1;
      end
    end
    for (int p = 0; p < 7; p++) begin
      src_bit[p] = (hdr_q.port == 3'(p + 1));
      dyn_bit[p] = (dyn_port == 3'(p + 1));
    end
    any_hit = rsv_hit | stat_hit | dyn_hit;
    if (rsv_hit) begin
      s1 = rsv_q[rsv_info[2:0]];
    end else if (stat_hit) begin
      s1 = stat_map;  // see (R9)
    end else if (dyn_hit) begin
      s1 = dyn_bit;  // see (R8)
    end else begin
      s1 = vlan_members;
    end
    adj = ((s1 & fwd_allow_mask) | mirror_ports) & ~src_bit;  // see (R17)
  end

  // ----------------------------------------------------------------
  // engine sequencing, learning and aging
  // ----------------------------------------------------------------
  assign hdr_ready  = (state_q == ST_IDLE) && !sweep_pend_q;
  assign mgmt_ready = hdr_ready && !hdr_valid;

  always_comb begin
    logic       hit, found, stat_only;
    logic [1:0] way;
    logic [1:0] best_age;
    hit          = 1'b0;
    found        = 1'b0;
    stat_only    = 1'b1;
    way          = '0;
    best_age     = `SAL_AGE_FULL;
    state_d      = state_q;
    hdr_d        = hdr_q;
    sweep_pend_d = sweep_pend_q | sweep_tick;
    sweep_idx_d  = sweep_idx_q;
    dec_valid_d  = 1'b0;
    s1_d         = s1_q;
    fin_d        = fin_q;
    drop_d       = drop_q;
    pause_d      = 1'b0;
    full_d       = 1'b0;
    full_idx_d   = full_idx_q;
    nb           = bkt;
    wr_en        = 1'b0;
    keep_static  = '0;
    unique case (state_q)
      ST_IDLE: begin
        if (sweep_pend_q) begin
          state_d      = ST_SWEEP;
          sweep_idx_d  = '0;
          sweep_pend_d = sweep_tick;
        end else if (hdr_valid) begin
          hdr_d   = hdr;
          state_d = ST_DA;
        end else if (dyn_wr) begin
          nb[dyn_wr_way] = dyn_wr_data;
          wr_en          = 1'b1;
        end
      end
      ST_DA: begin
        dec_valid_d     = 1'b1;
        s1_d            = s1;
        drop_d.err      = hdr_err;  // see (R19)
        drop_d.pause    = hdr_q.is_pause;  // see (R20)
        drop_d.is_local = any_hit && s1 == src_bit;  // see (R21)
        drop_d.mgmt     = hdr_q.is_mgmt;  // see (R22)
        pause_d         = hdr_q.is_pause;  // see (R20)
        fin_d           = acl_override ? acl_ports : adj;  // see (R18)
        if (hdr_err || hdr_q.is_pause || hdr_q.is_mgmt ||
            (any_hit && s1 == src_bit)) begin
          fin_d = '0;
        end
        state_d = ST_SA;
      end
      ST_SA: begin
        for (int w = WAYS - 1; w >= 0; w--) begin
          if (bkt[w].valid && bkt[w].mac == hdr_q.sa &&
              bkt[w].filter_group_id == hdr_q.filter_group_id) begin
            hit = 1'b1;
            way = 2'(w);
          end
        end
        if (hit) begin
          if (!hdr_err && !bkt[way].is_static) begin
            nb[way].age  = `SAL_AGE_FULL;  // see (R14)
            nb[way].port = hdr_q.port;  // see (R13)
            wr_en        = 1'b1;
          end
        end else if (!hdr_err && !hdr_q.sa[40]) begin  // see (R10)
          for (int w = WAYS - 1; w >= 0; w--) begin
            if (!bkt[w].valid) begin
              found = 1'b1;
              way   = 2'(w);
            end
          end
          for (int w = 0; w < WAYS; w++) begin
            if (!found && bkt[w].valid && !bkt[w].is_static) begin
              stat_only = 1'b0;
              if (bkt[w].age <= best_age) begin  // see (R11)
                best_age = bkt[w].age;
                way      = 2'(w);
              end
            end
          end
          if (found || !stat_only) begin
            nb[way] = '{valid: 1'b1, is_static: 1'b0, mac: hdr_q.sa,
                        filter_group_id: hdr_q.filter_group_id, port: hdr_q.port,
                        age: `SAL_AGE_FULL};  // see (R11)
            wr_en   = 1'b1;
          end else begin
            full_d     = 1'b1;  // see (R12)
            full_idx_d = sa_idx;
          end
        end
        state_d = ST_IDLE;
      end
      ST_SWEEP: begin
        for (int w = 0; w < WAYS; w++) begin
          keep_static[w] = bkt[w].valid && bkt[w].is_static;
          if (bkt[w].valid && !bkt[w].is_static) begin  // see (R16)
            if (bkt[w].age == 2'h0) begin
              nb[w].valid = 1'b0;  // see (R14)
            end else begin
              nb[w].age = bkt[w].age - 2'h1;
            end
          end
        end
        wr_en       = 1'b1;
        sweep_idx_d = sweep_idx_q + IDX_W'(1);
        if (sweep_idx_q == IDX_W'(NBKT - 1)) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q      <= ST_IDLE;
      hdr_q        <= '0;
      sweep_pend_q <= 1'b0;
      sweep_idx_q  <= '0;
      dec_valid_q  <= 1'b0;
      s1_q         <= '0;
      fin_q        <= '0;
      drop_q       <= '0;
      pause_q      <= 1'b0;
      full_q       <= 1'b0;
      full_idx_q   <= '0;
    end else begin
      state_q      <= state_d;
      hdr_q        <= hdr_d;
      sweep_pend_q <= sweep_pend_d;
      sweep_idx_q  <= sweep_idx_d;
      dec_valid_q  <= dec_valid_d;
      s1_q         <= s1_d;
      fin_q        <= fin_d;
      drop_q       <= drop_d;
      pause_q      <= pause_d;
      full_q       <= full_d;
      full_idx_q   <= full_idx_d;
    end
  end

  // ----------------------------------------------------------------
  // table storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NBKT; i++) begin
        tbl_q[i] <= '0;
      end
      for (int i = 0; i < `SAL_STAT_N; i++) begin
        stat_q[i] <= '0;
      end
      for (int i = 0; i < `SAL_RSV_N; i++) begin
        rsv_q[i] <= RSV_DEF[i];  // see (R3) (R4) (R5) (R6) (R7)
      end
    end else begin
      if (wr_en) begin
        tbl_q[rd_idx] <= nb;
      end
      if (stat_wr) begin
        stat_q[stat_wr_idx] <= stat_wr_data;  // see (R1)
      end
      if (rsv_wr) begin
        rsv_q[rsv_wr_grp] <= rsv_wr_map;  // see (R2)
      end
    end
  end

  assign dec_valid           = dec_valid_q;
  assign stage_one_port_list = s1_q;
  assign final_port_list     = fin_q;
  assign dec_drop            = drop_q;
  assign pause_seen          = pause_q;
  assign pause_port          = hdr_q.port;
  assign learn_full          = full_q;
  assign learn_full_index    = full_idx_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_err_no_fwd: assert property (@(posedge clk) disable iff (rst) // see (R19)
    dec_valid && dec_drop.err |-> final_port_list == 7'h00)
    else $error("error frame forwarded");
  a_pause_consume: assert property (@(posedge clk) disable iff (rst) // see (R20)
    dec_valid && dec_drop.pause |-> pause_seen && final_port_list == 7'h00)
    else $error("pause frame not consumed");
  a_local_drop: assert property (@(posedge clk) disable iff (rst) // see (R21)
    dec_valid && dec_drop.is_local |-> final_port_list == 7'h00)
    else $error("local frame forwarded");
  a_mgmt_drop: assert property (@(posedge clk) disable iff (rst) // see (R22)
    dec_valid && dec_drop.mgmt |-> final_port_list == 7'h00)
    else $error("management frame forwarded");
  a_acl_final: assert property (@(posedge clk) disable iff (rst) // see (R18)
    state_q == ST_DA && acl_override && !hdr_err && !hdr_q.is_pause &&
    !hdr_q.is_mgmt && !(any_hit && s1 == src_bit)
    |=> final_port_list == $past(acl_ports))
    else $error("acl result not applied");
  a_static_prio: assert property (@(posedge clk) disable iff (rst) // see (R9)
    state_q == ST_DA && stat_hit && !rsv_hit
    |=> stage_one_port_list == $past(stat_map))
    else $error("static entry lost priority");
  a_rsv_defaults: assert property (@(posedge clk) // see (R3)
    $past(rst) && !rst |-> rsv_q[0] == 7'h40 && rsv_q[1] == 7'h00 &&
    rsv_q[3] == 7'h7f && rsv_q[7] == 7'h3f)
    else $error("reserved bitmap defaults wrong");
  a_full_index: assert property (@(posedge clk) disable iff (rst) // see (R12)
    learn_full |-> $past(state_q) == ST_SA && learn_full_index == $past(sa_idx))
    else $error("full bucket index not captured");
  a_hdr_flow: assert property (@(posedge clk) disable iff (rst) // see (R8)
    hdr_valid && hdr_ready |=> state_q == ST_DA ##1 dec_valid && state_q == ST_SA)
    else $error("lookup sequence broken");
  a_sweep_static: assert property (@(posedge clk) disable iff (rst) // see (R16)
    state_q == ST_SWEEP |-> (keep_static & ~{nb[3].valid, nb[2].valid,
    nb[1].valid, nb[0].valid}) == 4'h0)
    else $error("aging removed a static entry");

endmodule

// file: shared/sal_consts.svh
// constants for the switch address lookup engine
// assumes a 25 MHz core clock and 7 switch ports numbered 1 to 7
`ifndef SAL_CONSTS_SVH
`define SAL_CONSTS_SVH

// ----------------------------------------------------------------
// table geometry
// ----------------------------------------------------------------
`define SAL_IDX_W        10
`define SAL_WAYS         4
`define SAL_STAT_N       16
`define SAL_RSV_N        8
`define SAL_AGE_FULL     2'h3

// ----------------------------------------------------------------
// reserved multicast groups
// ----------------------------------------------------------------
`define SAL_RSV_PREFIX   40'h0180c20000
`define SAL_RSV0_MAP     7'h40
`define SAL_RSV1_MAP     7'h00
`define SAL_RSV2_MAP     7'h40
`define SAL_RSV3_MAP     7'h7f
`define SAL_RSV4_MAP     7'h3f
`define SAL_RSV5_MAP     7'h3f
`define SAL_RSV6_MAP     7'h40
`define SAL_RSV7_MAP     7'h3f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SAL_CLK_HZ       25000000
`define SAL_QTR_CYC      (`SAL_CLK_HZ / 4)
`define SAL_AGE_PERIOD_S 11'd300
`define SAL_AGE_MIN_S    11'd1
`define SAL_AGE_MAX_S    11'd1800

`endif

// file: shared/sal_pkg.sv
// types shared by the address lookup engine files
// assumes sal_consts.svh is on the include path
`include "sal_consts.svh"

package sal_pkg;

  // --------------------------------------------------------------
  // addresses and port bitmaps
  // --------------------------------------------------------------
  typedef logic [47:0] sal_mac_t;
  typedef logic [6:0]  sal_pmap_t;

  typedef struct packed {
    sal_mac_t   da;
    sal_mac_t   sa;
    logic [6:0] filter_group_id;
    logic [2:0] port;
    logic       err_frame;
    logic       err_fcs;
    logic       err_align;
    logic       err_size;
    logic       is_pause;
    logic       is_mgmt;
  } sal_hdr_t;

  typedef struct packed {
    logic       valid;
    logic       is_static;
    sal_mac_t   mac;
    logic [6:0] filter_group_id;
    logic [2:0] port;
    logic [1:0] age;
  } sal_dyn_t;

  typedef sal_dyn_t [`SAL_WAYS-1:0] sal_bucket_t;

  typedef struct packed {
    logic       valid;
    sal_mac_t   mac;
    logic [6:0] filter_group_id;
    sal_pmap_t  ports;
  } sal_stat_t;

  typedef struct packed {
    logic err;
    logic pause;
    logic is_local;
    logic mgmt;
  } sal_drop_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DA,
    ST_SA,
    ST_SWEEP
  } sal_state_t;

endpackage

// file: test/sal_port_model.sv
// ingress port model: offers one header, holds it until taken
// assumes the engine samples hdr_valid and hdr_ready on the rising edge
`timescale 1ns/1ps

module sal_port_model
  import sal_pkg::*;
(
  input  logic     clk,
  input  logic     send,
  input  sal_hdr_t hdr_in,
  input  logic     hdr_ready,
  output logic     hdr_valid,
  output sal_hdr_t hdr
);
  initial begin
    hdr_valid = 1'b0;
    hdr       = '0;
  end

  // released header shows inverted contents, never a stale copy
  always @(posedge clk) begin
    if (hdr_valid && hdr_ready) begin
      hdr_valid <= 1'b0;
      hdr       <= ~hdr;
    end else if (send && !hdr_valid) begin
      hdr_valid <= 1'b1;
      hdr       <= hdr_in;
    end
  end
endmodule

// file: test/testbench.sv
// self-checking bench for the address lookup engine
// assumes sal_pkg is compiled first, sal_consts.svh on include path
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module testbench
  import sal_pkg::*;
;
  typedef struct packed {
    sal_mac_t   da;
    sal_mac_t   sa;
    logic [2:0] port;
    logic [5:0] fl;
    sal_pmap_t  fin;
    sal_drop_t  drp;
  } sal_row_t;

  localparam sal_mac_t A = 48'h0a01;
  localparam sal_mac_t B = 48'h0b02;
  localparam sal_mac_t C = 48'h0c03;
  localparam sal_mac_t D = 48'h0d05;
  localparam sal_mac_t E = 48'h0100_0000_0e04;
  localparam sal_mac_t F = 48'h0f06;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psend = 1'b0;
  logic hdr_valid, hdr_ready, dec_valid, pause_seen, learn_full, mgmt_ready;
  logic stat_wr = 1'b0, rsv_enable = 1'b0, rsv_wr = 1'b0, dyn_wr = 1'b0;
  logic acl_override = 1'b0, age_enable = 1'b0;
  logic [2:0] pause_port, rsv_wr_grp = 3'h0;
  logic [3:0] learn_full_index, stat_wr_idx = 4'h0, dyn_wr_idx = 4'h0;
  logic [1:0] dyn_wr_way = 2'h0;
  logic [10:0] age_period_s = 11'h000;
  sal_hdr_t hdr, ph = '0;
  sal_pmap_t vlan_members = 7'h7f, fwd_allow_mask = 7'h7f;
  sal_pmap_t mirror_ports = 7'h00, acl_ports = 7'h00, rsv_wr_map = 7'h00;
  sal_pmap_t stage_one_port_list, final_port_list;
  sal_drop_t dec_drop;
  sal_stat_t stat_wr_data = '0;
  sal_dyn_t dyn_wr_data = '0;
  int fails = 0;
  int samples_checked = 0;

  // first rows fill bucket 7 with learned sources, the fifth evicts one
  sal_row_t rows [22] = '{
    '{F, 48'h0007, 3'h1, 6'h00, 7'h7e, 4'h0},
    '{F, 48'h1007, 3'h2, 6'h00, 7'h7d, 4'h0},
    '{F, 48'h2007, 3'h3, 6'h00, 7'h7b, 4'h0},
    '{F, 48'h3007, 3'h4, 6'h00, 7'h77, 4'h0},
    '{F, 48'h4007, 3'h5, 6'h00, 7'h6f, 4'h0},
    '{48'h3007, 48'h0007, 3'h1, 6'h00, 7'h7e, 4'h0},
    '{48'h4007, 48'h0007, 3'h1, 6'h00, 7'h10, 4'h0},
    '{A, B, 3'h3, 6'h00, 7'h7b, 4'h0}, '{B, A, 3'h5, 6'h00, 7'h04, 4'h0},
    '{A, C, 3'h1, 6'h00, 7'h10, 4'h0}, '{B, A, 3'h6, 6'h00, 7'h04, 4'h0},
    '{A, C, 3'h1, 6'h00, 7'h20, 4'h0}, '{A, C, 3'h6, 6'h00, 7'h00, 4'h2},
    '{C, E, 3'h2, 6'h00, 7'h20, 4'h0}, '{E, B, 3'h3, 6'h00, 7'h7b, 4'h0},
    '{A, F, 3'h2, 6'h10, 7'h00, 4'h8}, '{F, B, 3'h3, 6'h00, 7'h7b, 4'h0},
    '{A, B, 3'h3, 6'h20, 7'h00, 4'h8}, '{A, B, 3'h3, 6'h08, 7'h00, 4'h8},
    '{A, B, 3'h3, 6'h04, 7'h00, 4'h8}, '{A, B, 3'h3, 6'h01, 7'h00, 4'h1},
    '{A, B, 3'h3, 6'h02, 7'h00, 4'h4}};
  logic [7:0] suf [10] = '{8'h00, 8'h01, 8'h03, 8'h10, 8'h20, 8'h21,
                           8'h02, 8'h11, 8'h0f, 8'h2f};
  sal_pmap_t rmap [10] = '{7'h40, 7'h00, 7'h40, 7'h7f, 7'h3f, 7'h3f,
                           7'h40, 7'h3f, 7'h40, 7'h3f};

  sal_port_model sal_port_model_i (.clk, .send(psend), .hdr_in(ph),
    .hdr_ready, .hdr_valid, .hdr);

  sal_lookup_engine #(.IDX_W(4), .QTR_CYC(64)) sal_lookup_engine_i (
    .clk, .rst, .hdr_valid, .hdr_ready, .hdr, .vlan_members,
    .fwd_allow_mask, .mirror_ports, .acl_override, .acl_ports, .dec_valid,
    .stage_one_port_list, .final_port_list, .dec_drop, .pause_seen,
    .pause_port, .learn_full, .learn_full_index, .mgmt_ready, .stat_wr,
    .stat_wr_idx, .stat_wr_data, .rsv_enable, .rsv_wr, .rsv_wr_grp,
    .rsv_wr_map, .dyn_wr, .dyn_wr_idx, .dyn_wr_way, .dyn_wr_data,
    .age_enable, .age_period_s);

  always #20 clk = ~clk;

  function automatic sal_hdr_t mk(sal_mac_t da, sal_mac_t sa,
                                  logic [2:0] p, logic [5:0] fl);
    return {da, sa, 7'h00, p, fl};
  endfunction

  // offer one header, wait for its decision
  task automatic run(input sal_hdr_t h);
    int n;
    @(negedge clk);
    ph = h;
    psend = 1'b1;
    @(negedge clk);
    psend = 1'b0;
    n = 0;
    while (dec_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) fails++;
  endtask

  task automatic results();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    fails++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    `CHK(final_port_list, 7'h00)
    `CHK(dec_valid, 1'b0)
    @(negedge clk);
    `CHK(hdr_ready, 1'b1)
    `CHK(mgmt_ready, 1'b1)
    foreach (rows[i]) begin
      run(mk(rows[i].da, rows[i].sa, rows[i].port, rows[i].fl));
      `CHK(final_port_list, rows[i].fin)
      `CHK(dec_drop, rows[i].drp)
      `CHK(pause_seen, rows[i].fl[1])
    end
    `CHK(pause_port, 3'h3)
    // static table entry beats learned entry
    @(negedge clk) stat_wr = 1'b1;
    stat_wr_data = {1'b1, A, 7'h00, 7'h22};
    @(negedge clk) stat_wr = 1'b0;
    run(mk(A, B, 3'h1, 6'h00));
    `CHK(stage_one_port_list, 7'h22)
    // reserved groups with default and rewritten bitmaps
    rsv_enable = 1'b1;
    foreach (suf[g]) begin
      run(mk({40'h0180c20000, suf[g]}, B, 3'h3, 6'h00));
      `CHK(stage_one_port_list, rmap[g])
    end
    @(negedge clk) rsv_wr = 1'b1;
    rsv_wr_grp = 3'h3;
    rsv_wr_map = 7'h05;
    @(negedge clk) rsv_wr = 1'b0;
    run(mk({40'h0180c20000, 8'h10}, B, 3'h3, 6'h00));
    `CHK(stage_one_port_list, 7'h05)
    // mirror, allow mask and acl override
    rsv_enable = 1'b0;
    vlan_members = 7'h03;
    mirror_ports = 7'h40;
    run(mk(F, B, 3'h1, 6'h00));
    `CHK(final_port_list, 7'h42)
    vlan_members = 7'h7f;
    mirror_ports = 7'h00;
    fwd_allow_mask = 7'h0f;
    run(mk(F, B, 3'h1, 6'h00));
    `CHK(final_port_list, 7'h0e)
    acl_override = 1'b1;
    acl_ports = 7'h11;
    run(mk(F, B, 3'h1, 6'h00));
    `CHK(final_port_list, 7'h11)
    acl_override = 1'b0;
    fwd_allow_mask = 7'h7f;
    // bucket 5 filled with static entries
    for (int w = 0; w < 4; w++) begin
      @(negedge clk) dyn_wr = 1'b1;
      dyn_wr_idx = 4'h5;
      dyn_wr_way = w[1:0];
      dyn_wr_data = {2'b11, 38'h0, w[1:0], 8'h05, 7'h00, 3'h1, 2'h3};
    end
    @(negedge clk) dyn_wr = 1'b0;
    run(mk(A, D, 3'h2, 6'h00));
    @(negedge clk);
    `CHK(learn_full, 1'b1)
    `CHK(learn_full_index, 4'h5)
    run(mk(D, B, 3'h3, 6'h00));
    `CHK(final_port_list, 7'h7b)
    // aging removes learned entries, keeps static ones
    age_period_s = 11'h001;
    age_enable = 1'b1;
    repeat (1200) @(posedge clk);
    @(negedge clk) age_enable = 1'b0;
    run(mk(C, B, 3'h1, 6'h00));
    `CHK(final_port_list, 7'h7e)
    run(mk(48'h0005, B, 3'h3, 6'h00));
    `CHK(final_port_list, 7'h01)
    // second reset restores default reserved bitmaps
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rsv_enable = 1'b1;
    run(mk({40'h0180c20000, 8'h10}, B, 3'h3, 6'h00));
    `CHK(stage_one_port_list, 7'h7f)
    results();
  end
endmodule
